// ---- src/scmh_consts.svh ----
// Constants for the initiator-side message handler: message codes,
// Identify field positions and timing counts.
// Assumes a 40 MHz controller clock.
`ifndef SCMH_CONSTS_SVH
`define SCMH_CONSTS_SVH

// Message codes
`define SCMH_MSG_CMD_DONE 8'h00
`define SCMH_MSG_SAVE_PTR 8'h02
`define SCMH_MSG_RESTORE_PTR 8'h03
`define SCMH_MSG_DISCONNECT 8'h04
`define SCMH_MSG_INIT_ERR 8'h05
`define SCMH_MSG_ABORT 8'h06
`define SCMH_MSG_REJECT 8'h07
`define SCMH_MSG_NOP 8'h08
`define SCMH_MSG_LINK_DONE 8'h0a
`define SCMH_MSG_LINK_FLAG 8'h0b
`define SCMH_MSG_BUS_RESET 8'h0c

// Identify layout
`define SCMH_ID_BASE 8'h80
`define SCMH_ID_TOP_BIT 7
`define SCMH_ID_DISC_BIT 6
`define SCMH_ID_RSV_HI 5
`define SCMH_ID_RSV_LO 3
`define SCMH_ID_LUN_HI 2
`define SCMH_ID_LUN 3'h0

// Timing
`define SCMH_CLK_MHZ 40
`define SCMH_SETTLE_NS 100
`define SCMH_SETTLE_CYC ((`SCMH_SETTLE_NS * `SCMH_CLK_MHZ + 999) / 1000)
`define SCMH_SEL_TIMEOUT_US 250000
`define SCMH_SEL_TIMEOUT_CYC (`SCMH_SEL_TIMEOUT_US * `SCMH_CLK_MHZ)
`define SCMH_CNT_W 24
`define SCMH_SYNC_W 13

`endif

// ---- src/scmh_pkg.sv ----
// Types and Identify decode and build functions shared by the initiator message handler.
// Relies on scmh_consts.svh for the field positions.
`include "scmh_consts.svh"

package scmh_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SEL_ATN,
        ST_SEL_WAIT,
        ST_CONN,
        ST_DRIVE,
        ST_ACK
    } scmh_state_t;

    // Identify byte recognised by its top bit
    function automatic logic scmh_is_identify(input logic [7:0] b);
        scmh_is_identify = b[`SCMH_ID_TOP_BIT];
    endfunction

    // Identify with reserved bits and unit number clear
    function automatic logic scmh_id_clean(input logic [7:0] b);
        scmh_id_clean = b[`SCMH_ID_TOP_BIT]
            && (b[`SCMH_ID_RSV_HI:`SCMH_ID_RSV_LO] == 3'h0)
            && (b[`SCMH_ID_LUN_HI:0] == `SCMH_ID_LUN);
    endfunction

    // Identify this end sends, disconnect ability in bit 6
    function automatic logic [7:0] scmh_make_identify(input logic disc);
        logic [7:0] b;
        b = `SCMH_ID_BASE;
        b[`SCMH_ID_DISC_BIT] = disc;
        scmh_make_identify = b;
    endfunction

endpackage

// ---- src/scmh_sync.sv ----
// Two-flop synchroniser for the bus pins seen by the initiator.
// Assumes every D bit is asynchronous to CLK; RST is sampled on the clock.
`timescale 1ns/10ps
`include "scmh_consts.svh"

module scmh_sync
    import scmh_pkg::*;
#(
    parameter int W = `SCMH_SYNC_W
)
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic [W-1:0] D,
    output logic [W-1:0] Q
);

    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // First stage feeds only the second stage
    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            always_ff @(posedge CLK)
            begin
                if (RST)
                begin
                    meta_q[i] <= 1'b0;
                    sync_q[i] <= 1'b0;
                end
                else
                begin
                    meta_q[i] <= D[i];
                    sync_q[i] <= meta_q[i];
                end
            end
        end
    endgenerate

    assign Q = sync_q;

endmodule

// ---- src/scmh_initiator.sv ----
// Initiator-side message handler: selects a tape target, answers its
// REQ/ACK byte handshakes and exchanges messages with it.
// Assumes pins are asynchronous and the bus wiring resolves DB from DB_OE.
`timescale 1ns/10ps
`include "scmh_consts.svh"

module scmh_initiator
    import scmh_pkg::*;
#(
    parameter int SEL_TIMEOUT_CYC = `SCMH_SEL_TIMEOUT_CYC
)
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic BSY_I,
    input wire logic REQ_I,
    input wire logic IO_I,
    input wire logic CD_I,
    input wire logic MSG_I,
    input wire logic [7:0] DB_I,
    output logic [7:0] DB_O,
    output logic DB_OE,
    output logic SEL_O,
    output logic ATN_O,
    output logic ACK_O,
    input wire logic START,
    input wire logic [7:0] SEL_IDS,
    input wire logic DISC_OK,
    input wire logic ABORT_REQ,
    input wire logic BDR_REQ,
    input wire logic ERR_REQ,
    input wire logic [7:0] TX_BYTE,
    output logic TX_TAKE,
    output logic [7:0] RX_BYTE,
    output logic RX_VALID,
    output logic CONNECTED,
    output logic SEL_FAIL,
    output logic BUS_FREE,
    output logic CMD_DONE,
    output logic LINK_DONE,
    output logic LINK_FLAG,
    output logic SAVE_PTR,
    output logic RESTORE_PTR,
    output logic DISC_SEEN,
    output logic REJECT_SEEN,
    output logic BAD_ID
);
    localparam logic [`SCMH_CNT_W-1:0] SETTLE = `SCMH_CNT_W'(`SCMH_SETTLE_CYC);
    localparam logic [`SCMH_CNT_W-1:0] SEL_TO = `SCMH_CNT_W'(SEL_TIMEOUT_CYC);
    scmh_state_t st_q, st_d;
    logic [`SCMH_CNT_W-1:0] cnt_q, cnt_d;
    logic [12:0] pins_s;
    logic bsy_s, req_s, io_s, cd_s, msg_s;
    logic [7:0] db_s;
    logic atn_q, atn_d, sel_q, sel_d, ack_q, ack_d, oe_q, oe_d;
    logic [7:0] dbo_q, dbo_d;
    logic first_q, first_d, mout_q, mout_d;
    logic pend_v_q, pend_v_d;
    logic [7:0] pend_q, pend_d;
    logic [10:0] evt_q, evt_d;
    logic [7:0] rx_q;
    logic tx_take_q;
    scmh_sync #(.W(`SCMH_SYNC_W)) u_sync (
        .CLK(CLK),
        .RST(RST),
        .D({BSY_I, REQ_I, IO_I, CD_I, MSG_I, DB_I}),
        .Q(pins_s)
    );
    // Synchronised pins and phase decode
    assign {bsy_s, req_s, io_s, cd_s, msg_s, db_s} = pins_s;
    wire msg_phase = msg_s & cd_s;
    wire bus_free = !bsy_s && !sel_q;
    wire cnt_zero = (cnt_q == '0);
    wire req_new = (st_q == ST_CONN) && bsy_s && req_s;
    wire take_in = req_new && io_s;
    wire take_out = req_new && !io_s;
    wire msg_in = take_in && msg_phase;
    wire [7:0] id_out = scmh_make_identify(DISC_OK);
    wire pend_first = pend_v_q && ((pend_q == `SCMH_MSG_ABORT)
        || (pend_q == `SCMH_MSG_BUS_RESET));
    // First byte Identify unless Abort or reset waits; else pending or no-op
    wire [7:0] mout_byte = first_q ? (pend_first ? pend_q : id_out)
        : (pend_v_q ? pend_q : `SCMH_MSG_NOP);
    wire mout_sent = (st_q == ST_DRIVE) && cnt_zero && mout_q;
    // Incoming message classification
    wire in_id = scmh_is_identify(db_s);
    wire in_bad_id = in_id && !scmh_id_clean(db_s);
    wire in_known = in_id || (db_s == `SCMH_MSG_CMD_DONE)
        || (db_s == `SCMH_MSG_LINK_DONE) || (db_s == `SCMH_MSG_LINK_FLAG)
        || (db_s == `SCMH_MSG_SAVE_PTR) || (db_s == `SCMH_MSG_DISCONNECT)
        || (db_s == `SCMH_MSG_REJECT);
    wire need_reject = msg_in && (!in_known || in_bad_id);
    // User requests and automatic reject, highest first: reset, abort, error report, reject
    wire req_any = BDR_REQ || ABORT_REQ || ERR_REQ || need_reject;
    wire [7:0] req_code = BDR_REQ ? `SCMH_MSG_BUS_RESET
        : ABORT_REQ ? `SCMH_MSG_ABORT
        : ERR_REQ ? `SCMH_MSG_INIT_ERR
        : `SCMH_MSG_REJECT;
    wire conn = (st_q != ST_IDLE) && (st_q != ST_SEL_ATN);
    // Pending message slot; a new request wins over the send that clears it
    always_comb
    begin
        pend_v_d = pend_v_q;
        pend_d = pend_q;
        if (mout_sent && (!first_q || pend_first))
            pend_v_d = 1'b0;
        if (req_any && conn)
        begin
            pend_v_d = 1'b1;
            pend_d = req_code;
        end
        if (st_d == ST_IDLE)
            pend_v_d = 1'b0;
    end
    // Sequencer for selection and byte handshakes
    always_comb
    begin
        st_d = st_q;
        cnt_d = cnt_zero ? cnt_q : cnt_q - `SCMH_CNT_W'(1);
        atn_d = atn_q;
        sel_d = sel_q;
        ack_d = ack_q;
        oe_d = oe_q;
        dbo_d = dbo_q;
        first_d = first_q;
        mout_d = mout_q;
        evt_d = '0;
        case (st_q)
            ST_IDLE:
            begin
                atn_d = 1'b0;
                if (START && bus_free)
                begin
                    atn_d = 1'b1;
                    oe_d = 1'b1;
                    dbo_d = SEL_IDS;
                    cnt_d = SETTLE;
                    st_d = ST_SEL_ATN;
                end
            end
            ST_SEL_ATN:
            begin
                if (cnt_zero)
                begin
                    sel_d = 1'b1;
                    cnt_d = SEL_TO;
                    st_d = ST_SEL_WAIT;
                end
            end
            ST_SEL_WAIT:
            begin
                if (bsy_s)
                begin
                    sel_d = 1'b0;
                    oe_d = 1'b0;
                    first_d = 1'b1;
                    st_d = ST_CONN;
                end
                else if (cnt_zero)
                begin
                    sel_d = 1'b0;
                    oe_d = 1'b0;
                    atn_d = 1'b0;
                    evt_d[10] = 1'b1;
                    st_d = ST_IDLE;
                end
            end
            ST_CONN:
            begin
                if (!bsy_s)
                begin
                    evt_d[9] = 1'b1;
                    st_d = ST_IDLE;
                end
                else if (take_in)
                begin
                    ack_d = 1'b1;
                    evt_d[8] = !msg_phase;
                    evt_d[0] = msg_in && (db_s == `SCMH_MSG_CMD_DONE);
                    evt_d[1] = msg_in && (db_s == `SCMH_MSG_LINK_DONE);
                    evt_d[2] = msg_in && (db_s == `SCMH_MSG_LINK_FLAG);
                    evt_d[3] = msg_in && (db_s == `SCMH_MSG_SAVE_PTR);
                    evt_d[4] = msg_in && in_id && !in_bad_id;
                    evt_d[5] = msg_in && (db_s == `SCMH_MSG_DISCONNECT);
                    evt_d[6] = msg_in && (db_s == `SCMH_MSG_REJECT);
                    evt_d[7] = msg_in && in_bad_id;
                    if (need_reject)
                        atn_d = 1'b1;
                    st_d = ST_ACK;
                end
                else if (take_out)
                begin
                    mout_d = msg_phase;
                    dbo_d = msg_phase ? mout_byte : TX_BYTE;
                    oe_d = 1'b1;
                    cnt_d = SETTLE;
                    st_d = ST_DRIVE;
                end
                else if (pend_v_q)
                    atn_d = 1'b1;
            end
            ST_DRIVE:
            begin
                if (cnt_zero)
                begin
                    ack_d = 1'b1;
                    if (mout_q)
                    begin
                        first_d = 1'b0;
                        atn_d = pend_v_d; // Drop ATN on the last message byte
                    end
                    st_d = ST_ACK;
                end
            end
            ST_ACK:
            begin
                if (!req_s)
                begin
                    ack_d = 1'b0;
                    oe_d = 1'b0;
                    st_d = ST_CONN;
                end
            end
            default: st_d = ST_IDLE;
        endcase
    end
    // State registers
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            st_q <= ST_IDLE;
            cnt_q <= '0;
            {atn_q, sel_q, ack_q, oe_q, first_q, mout_q} <= 6'h00;
            dbo_q <= 8'h00;
            pend_v_q <= 1'b0;
            pend_q <= 8'h00;
            evt_q <= 11'h000;
        end
        else
        begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            {atn_q, sel_q, ack_q, oe_q, first_q, mout_q} <=
                {atn_d, sel_d, ack_d, oe_d, first_d, mout_d};
            dbo_q <= dbo_d;
            pend_v_q <= pend_v_d;
            pend_q <= pend_d;
            evt_q <= evt_d;
        end
    end
    // Received data byte and user byte taken
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            rx_q <= 8'h00;
            tx_take_q <= 1'b0;
        end
        else
        begin
            rx_q <= take_in ? db_s : rx_q;
            tx_take_q <= (st_q == ST_DRIVE) && cnt_zero && !mout_q;
        end
    end
    // Pin and user outputs
    assign DB_O = dbo_q;
    assign DB_OE = oe_q;
    assign SEL_O = sel_q;
    assign ATN_O = atn_q;
    assign ACK_O = ack_q;
    assign TX_TAKE = tx_take_q;
    assign RX_BYTE = rx_q;
    assign RX_VALID = evt_q[8];
    assign CONNECTED = (st_q == ST_CONN) || (st_q == ST_DRIVE) || (st_q == ST_ACK);
    assign {SEL_FAIL, BUS_FREE} = evt_q[10:9];
    assign {BAD_ID, REJECT_SEEN, DISC_SEEN, RESTORE_PTR} = evt_q[7:4];
    assign {SAVE_PTR, LINK_FLAG, LINK_DONE, CMD_DONE} = evt_q[3:0];
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    atn_before_sel_a: assert property ($rose(SEL_O) |-> ATN_O && $past(ATN_O))
        else $error("SEL rose without ATN already set");
    first_ident_a: assert property (mout_sent && first_q && !pend_first
        |-> DB_O == id_out)
        else $error("first message out was not Identify");
    id_fields_a: assert property (mout_sent && DB_O[7]
        |-> DB_O[5:3] == 3'h0 && DB_O[2:0] == 3'h0)
        else $error("Identify sent with reserved or unit bits set");
    disc_bit_a: assert property (mout_sent && DB_O[7]
        |-> DB_O[6] == DISC_OK)
        else $error("Identify disconnect bit does not follow DISC_OK");
    id_range_a: assert property (mout_sent && DB_O[7]
        |-> (DB_O >= 8'h80 && DB_O <= 8'h87) || (DB_O >= 8'hc0 && DB_O <= 8'hc7))
        else $error("Identify code outside allowed ranges");
    nop_empty_a: assert property (mout_sent && !first_q && !pend_v_q
        |-> DB_O == `SCMH_MSG_NOP)
        else $error("empty message out was not no-op");
    err_code_a: assert property (ERR_REQ && !BDR_REQ && !ABORT_REQ && conn
        && st_d != ST_IDLE |=> pend_v_q && pend_q == `SCMH_MSG_INIT_ERR)
        else $error("error report not queued as 05h");
    restore_early_a: assert property (msg_in && in_id && !in_bad_id
        |=> RESTORE_PTR && ACK_O ##1 !RESTORE_PTR)
        else $error("restore pulse not aligned with Identify ACK");
    ack_drop_a: assert property (st_q == ST_ACK && !req_s |=> !ACK_O && !DB_OE)
        else $error("ACK held after REQ released");
    reject_atn_a: assert property (need_reject && st_d == ST_ACK |=> ATN_O)
        else $error("ATN not raised to reject bad message");
    sel_ok_c: cover property (st_q == ST_SEL_WAIT && bsy_s ##1 CONNECTED);
    ident_c: cover property (mout_sent && first_q);
    done_c: cover property (CMD_DONE ##[1:200] BUS_FREE);
    reject_c: cover property (need_reject);

endmodule

// ---- verif/scmh_tgt_model.sv ----
// Behavioural tape target on the far side of the initiator handler.
// Assumes the bench resolves db_w from the handler's enable and calls these tasks.
`timescale 1ns/10ps
`include "scmh_consts.svh"

module scmh_tgt_model
(
    input wire logic clk,
    input wire logic sel,
    input wire logic atn,
    input wire logic ack,
    input wire logic [7:0] db_w,
    output logic bsy,
    output logic req,
    output logic [2:0] ph,
    output logic [7:0] db_t
);
    logic busy = 1'b0;
    logic atn_sel = 1'b0;
    logic [7:0] sel_db = 8'h00;

    // Bus released at start
    initial
    begin
        bsy = 1'b0;
        req = 1'b0;
        ph = 3'h0;
        db_t = 8'h00;
    end

    // Bounded wait for acknowledge at a level, looked at where it is settled
    task automatic wait_ack(input logic lvl);
        int i;
        for (i = 0; i < 200 && ack !== lvl; i++)
            @(negedge clk);
        if (ack !== lvl)
            tb_top.hang("target_ack");
    endtask

    // One byte handshake in phase ph; out phases capture rx
    task automatic xfer(input logic [2:0] p, input logic [7:0] tx, output logic [7:0] rx);
        @(negedge clk);
        ph = p;
        db_t = tx;
        @(negedge clk);
        req = 1'b1;
        wait_ack(1'b1);
        rx = db_w;
        @(negedge clk);
        req = 1'b0;
        db_t = ~tx;  // Released data shows no stale value
        wait_ack(1'b0);
    endtask

    // Answer selection, noting attention and the id bits first
    task automatic select_me();
        int i;
        for (i = 0; i < 50 && sel !== 1'b1; i++)
            @(negedge clk);
        if (sel !== 1'b1)
            tb_top.hang("target_sel");
        atn_sel = atn;
        sel_db = db_w;
        @(negedge clk);
        bsy = 1'b1;
    endtask

    // Drop the bus
    task automatic free();
        @(negedge clk);
        bsy = 1'b0;
        ph = 3'h0;
    endtask

    // Message-Out while attention is up, then act on the byte
    task automatic serve(output logic [7:0] b);
        logic [7:0] d;
        b = 8'hff;
        if (atn === 1'b1)
            xfer(3'b011, 8'h00, b);
        if (busy && (b == `SCMH_MSG_ABORT || b == `SCMH_MSG_INIT_ERR))
            xfer(3'b111, `SCMH_MSG_REJECT, d);
        else if (b == `SCMH_MSG_ABORT || b == `SCMH_MSG_BUS_RESET)
            free();
        else if (b[7] && b[5:0] != 6'h00)
            xfer(3'b111, `SCMH_MSG_REJECT, d);
    endtask

    // Reconnect Identify naming unit zero
    task automatic ident_in();
        logic [7:0] d;
        xfer(3'b111, `SCMH_ID_BASE | {5'h00, `SCMH_ID_LUN}, d);
    endtask

    // Ending message after status; only Command Complete drops the bus
    task automatic finish(input logic link, input logic flag);
        logic [7:0] d;
        logic [7:0] c;
        c = flag ? `SCMH_MSG_LINK_FLAG : `SCMH_MSG_LINK_DONE;
        xfer(3'b111, link ? c : `SCMH_MSG_CMD_DONE, d);
        if (!link)
            free();
    endtask
endmodule

// ---- verif/tb_top.sv ----
// Self-checking bench for the initiator message handler.
// Assumes the target model drives the bus lines released as logical false.
`timescale 1ns/10ps
`include "scmh_consts.svh"

module tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic start = 1'b0;
    logic disc_ok = 1'b0;
    logic abort_req = 1'b0;
    logic bdr_req = 1'b0;
    logic err_req = 1'b0;
    logic bsy, req, db_oe, sel_o, atn_o, ack_o, tx_take, rx_valid, connected, sel_fail;
    logic bus_free, cmd_done, link_done, link_flag, save_ptr, restore_ptr, disc_seen;
    logic reject_seen, bad_id;
    logic [2:0] ph;
    logic [7:0] db_o, db_t, db_w, rx_byte;
    logic [11:0] seen = 12'h000;
    int n_errors = 0;
    int checked = 0;

    // Clock and wire resolution
    always #12.5 clk = ~clk;
    assign db_w = db_oe ? db_o : db_t;

    // Sticky record of event pulses
    always @(posedge clk)
    begin
        seen <= seen | {sel_fail, bus_free, rx_valid, tx_take, bad_id, restore_ptr,
            reject_seen, disc_seen, save_ptr, link_flag, link_done, cmd_done};
    end

    scmh_initiator #(.SEL_TIMEOUT_CYC(200)) dut
    (
        .CLK(clk), .RST(rst), .BSY_I(bsy), .REQ_I(req), .IO_I(ph[2]), .CD_I(ph[1]),
        .MSG_I(ph[0]), .DB_I(db_w), .DB_O(db_o), .DB_OE(db_oe), .SEL_O(sel_o),
        .ATN_O(atn_o), .ACK_O(ack_o), .START(start), .SEL_IDS(8'h41), .DISC_OK(disc_ok),
        .ABORT_REQ(abort_req), .BDR_REQ(bdr_req), .ERR_REQ(err_req), .TX_BYTE(8'h5a),
        .TX_TAKE(tx_take), .RX_BYTE(rx_byte), .RX_VALID(rx_valid), .CONNECTED(connected),
        .SEL_FAIL(sel_fail), .BUS_FREE(bus_free), .CMD_DONE(cmd_done),
        .LINK_DONE(link_done), .LINK_FLAG(link_flag), .SAVE_PTR(save_ptr),
        .RESTORE_PTR(restore_ptr), .DISC_SEEN(disc_seen), .REJECT_SEEN(reject_seen),
        .BAD_ID(bad_id)
    );

    scmh_tgt_model tgt
    (
        .clk(clk), .sel(sel_o), .atn(atn_o), .ack(ack_o), .db_w(db_w), .bsy(bsy),
        .req(req), .ph(ph), .db_t(db_t)
    );

    // Compare and count
    task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
        checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Verdict and end of run
    task automatic results();
        if (n_errors == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // A bounded wait ran out
    task automatic hang(input string name);
        chk(name, 12'h1, 12'h0);
        results();
    endtask

    // Clear the event record
    task automatic clr();
        @(negedge clk);
        seen <= 12'h000;
    endtask

    // Wait for one recorded event
    task automatic wait_seen(input int b);
        int i;
        for (i = 0; i < 400 && seen[b] !== 1'b1; i++)
            @(negedge clk);
        if (seen[b] !== 1'b1)
            hang("event_wait");
    endtask

    // Select with attention, then check the Identify sent
    task automatic connect(input logic disc);
        logic [7:0] b;
        int i;
        repeat (4) @(negedge clk);
        disc_ok = disc;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        tgt.select_me();
        for (i = 0; i < 50 && connected !== 1'b1; i++)
            @(negedge clk);
        chk("connected", 12'h1, {11'h0, connected});
        chk("atn_at_select", 12'h1, {11'h0, tgt.atn_sel});
        chk("sel_ids", 12'h041, {4'h0, tgt.sel_db});
        tgt.serve(b);
        chk("identify_out", {4'h0, 1'b1, disc, 6'h00}, {4'h0, b});
        chk("atn_after_id", 12'h0, {11'h0, atn_o});
    endtask

    // Host message request, served in Message-Out
    task automatic host_msg(input int k, input logic [7:0] exp);
        logic [7:0] b;
        int i;
        clr();
        {bdr_req, abort_req, err_req} = 3'b001 << k;
        @(negedge clk);
        {bdr_req, abort_req, err_req} = 3'b000;
        for (i = 0; i < 20 && atn_o !== 1'b1; i++)
            @(negedge clk);
        tgt.serve(b);
        chk("host_msg", {4'h0, exp}, {4'h0, b});
    endtask

    // Selection with no answer times out
    task automatic t_timeout();
        clr();
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        wait_seen(11);
        chk("sel_fail", 12'h800, seen);
        chk("sel_lines", 12'h0, {9'h0, sel_o, atn_o, db_oe});
    endtask

    // Both Identify forms, Command Complete then bus free
    task automatic t_end();
        int d;
        for (d = 0; d < 2; d++)
        begin
            connect(d[0]);
            clr();
            tgt.finish(1'b0, 1'b0);
            wait_seen(10);
            chk("end_events", 12'h401, seen);
        end
    endtask

    // Incoming messages and data bytes
    task automatic t_msgin();
        logic [7:0] b;
        int f;
        connect(1'b1);
        for (f = 0; f < 2; f++)
        begin
            clr();
            tgt.finish(1'b1, f[0]);
            chk("link_event", 12'h002 << f, seen);
        end
        clr();
        tgt.xfer(3'b111, `SCMH_MSG_SAVE_PTR, b);
        chk("save_event", 12'h008, seen);
        clr();
        tgt.xfer(3'b000, 8'h00, b);
        chk("data_out", {4'h1, 8'h5a}, {seen[11:8], b});
        clr();
        tgt.xfer(3'b100, 8'ha5, b);
        chk("data_in", {4'h2, 8'ha5}, {seen[11:8], rx_byte});
        clr();
        tgt.xfer(3'b111, `SCMH_MSG_DISCONNECT, b);
        tgt.free();
        wait_seen(10);
        chk("disc_events", 12'h410, seen);
    endtask

    // Reconnect Identify, unclean Identify, nothing pending
    task automatic t_idin();
        logic [7:0] b;
        connect(1'b1);
        clr();
        tgt.ident_in();
        chk("restore_event", 12'h040, seen);
        clr();
        tgt.xfer(3'b111, 8'h81, b);
        chk("bad_id", 12'h080, seen);
        chk("reject_atn", 12'h1, {11'h0, atn_o});
        tgt.serve(b);
        chk("reject_out", {4'h0, `SCMH_MSG_REJECT}, {4'h0, b});
        tgt.xfer(3'b011, 8'h00, b);
        chk("nop_out", {4'h0, `SCMH_MSG_NOP}, {4'h0, b});
        tgt.finish(1'b0, 1'b0);
    endtask

    // Error report, abort while busy and idle, bus device reset
    task automatic t_hostreq();
        connect(1'b1);
        host_msg(0, `SCMH_MSG_INIT_ERR);
        tgt.busy = 1'b1;
        host_msg(1, `SCMH_MSG_ABORT);
        chk("busy_reject", 12'h020, seen);
        tgt.busy = 1'b0;
        host_msg(1, `SCMH_MSG_ABORT);
        wait_seen(10);
        connect(1'b0);
        host_msg(2, `SCMH_MSG_BUS_RESET);
        wait_seen(10);
        chk("reset_free", 12'h0, {11'h0, connected});
    endtask

    // Main sequence
    initial
    begin
        repeat (6) @(negedge clk);
        rst = 1'b0;
        t_timeout();
        t_end();
        t_msgin();
        t_idin();
        t_hostreq();
        results();
    end
endmodule
